// file: rtl/lisf_top.sv
// module: out-of-limit status flags, read-clear status registers and interrupt pin
//
// What this block does
// - internal temp above high limit sets S1.D0
// - internal temp at/below low limit sets S1.D1
// - diode mode: external temp above high sets S1.D2
// - analog mode: input 1 out of window sets S1.D2
// - external temp at/below low limit sets S1.D3
// - external diode open/short fault sets S1.D4
// - inputs 2-4 out of window set S1.D5-D7
// - inputs 5-8 out of window set S2.D0-D3
// - supply out of window sets S2.D4
// - read clears only flags whose condition ended
// - software reset clears both status registers, except flags set in that same cycle
// - all flags zero after power-up
// - status-two flags also drive interrupt pin
// - masked channels record no flag
// - interrupt active at set polarity while flags present
// - compare 10-bit results against 8-bit limits
`timescale 1ns/10ps
module lisf_top
   import lisf_pkg::*;
(
   // clock and reset
   input  wire logic                                mclk_in,
   input  wire logic                                rstn_in,
   // conversion results, one per channel: int, ext/in1, in2..in8, supply
   input  wire logic [LISF_NCHAN-1:0][LISF_RES_W-1:0] result_in,
   input  wire logic [LISF_NCHAN-1:0]               result_valid_in,
   input  wire logic [LISF_NCHAN-1:0][LISF_LIM_W-1:0] high_lim_in,
   input  wire logic [LISF_NCHAN-1:0][LISF_LIM_W-1:0] low_lim_in,
   // configuration
   input  wire lisf_pins_t                          pin_mode_in,
   input  wire logic [7:0]                          mask_first_in,
   input  wire logic [7:0]                          mask_second_in,
   input  wire logic                                int_active_high_in,
   input  wire logic                                diode_fault_in,
   input  wire logic                                soft_rst_in,
   // register read port
   input  wire logic                                rd_en_in,
   input  wire logic [7:0]                          rd_addr_in,
   output logic [7:0]                               rd_data_out,
   // interrupt pin
   output logic                                     int_out
);
   import lisf_pkg::*;

   // ----------------------------------------
   // comparators
   // ----------------------------------------
   logic [LISF_NCHAN-1:0] above;
   logic [LISF_NCHAN-1:0] at_or_below;
   logic [LISF_NCHAN-1:0] is_temp;

   always_comb begin
      is_temp = '0;
      is_temp[LISF_CH_INT] = 1'b1;
      is_temp[LISF_CH_EXT] = (pin_mode_in == LISF_PINS_DIODE);
   end

   genvar gi;
   generate
      for (gi = 0; gi < LISF_NCHAN; gi++) begin : g_cmp
         lisf_limit_cmp u_cmp (
            .result_in       (result_in[gi]),
            .high_lim_in     (high_lim_in[gi]),
            .low_lim_in      (low_lim_in[gi]),
            .signed_in       (is_temp[gi]),
            .above_out       (above[gi]),
            .at_or_below_out (at_or_below[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // live conditions and set events
   // ----------------------------------------
   logic [7:0] live_first;
   logic [7:0] live_second;
   logic [7:0] upd_first;
   logic [7:0] upd_second;
   logic [7:0] set_first;
   logic [7:0] set_second;
   logic       ext_window;
   logic       ext_valid;

   // last outcome per channel, held between conversions
   logic [7:0] cond_first_r;
   logic [7:0] cond_first_nxt;
   logic [7:0] cond_second_r;
   logic [7:0] cond_second_nxt;

   always_comb begin
      ext_valid = result_valid_in[LISF_CH_EXT];
      if (pin_mode_in == LISF_PINS_DIODE) begin
         ext_window = above[LISF_CH_EXT];
      end else begin
         ext_window = above[LISF_CH_EXT] | at_or_below[LISF_CH_EXT];
      end
      live_first = '0;
      upd_first  = '0;
      live_first[LISF_S1_INT_HIGH] = above[LISF_CH_INT];
      live_first[LISF_S1_INT_LOW]  = at_or_below[LISF_CH_INT];
      upd_first[LISF_S1_INT_HIGH]  = result_valid_in[LISF_CH_INT];
      upd_first[LISF_S1_INT_LOW]   = result_valid_in[LISF_CH_INT];
      live_first[LISF_S1_EXT_HIGH] = ext_window;
      upd_first[LISF_S1_EXT_HIGH]  = ext_valid;
      live_first[LISF_S1_EXT_LOW]  = (pin_mode_in == LISF_PINS_DIODE)
                                     & at_or_below[LISF_CH_EXT];
      upd_first[LISF_S1_EXT_LOW]   = ext_valid;
      live_first[LISF_S1_FAULT]    = diode_fault_in
                                     & (pin_mode_in == LISF_PINS_DIODE);
      upd_first[LISF_S1_FAULT]     = 1'b1;
      for (int i = 0; i < 3; i++) begin
         live_first[LISF_S1_ANALOG_INPUT_2+i] = above[LISF_CH_ANALOG_INPUT_2+i]
                                      | at_or_below[LISF_CH_ANALOG_INPUT_2+i];
         upd_first[LISF_S1_ANALOG_INPUT_2+i]  = result_valid_in[LISF_CH_ANALOG_INPUT_2+i];
      end
      live_second = '0;
      upd_second  = '0;
      for (int i = 0; i < 4; i++) begin
         live_second[LISF_S2_ANALOG_INPUT_5+i] = above[LISF_CH_ANALOG_INPUT_5+i]
                                       | at_or_below[LISF_CH_ANALOG_INPUT_5+i];
         upd_second[LISF_S2_ANALOG_INPUT_5+i]  = result_valid_in[LISF_CH_ANALOG_INPUT_5+i];
      end
      live_second[LISF_S2_SUPPLY] = above[LISF_CH_SUP] | at_or_below[LISF_CH_SUP];
      upd_second[LISF_S2_SUPPLY]  = result_valid_in[LISF_CH_SUP];
      // masked channels neither set nor hold a condition
      live_first  = live_first & ~mask_first_in;
      live_second = live_second & ~mask_second_in & LISF_SECOND_IMPL_MASK;
      set_first   = live_first & upd_first;
      set_second  = live_second & upd_second;
      cond_first_nxt  = ((cond_first_r & ~upd_first) | set_first) & ~mask_first_in;
      cond_second_nxt = ((cond_second_r & ~upd_second) | set_second) & ~mask_second_in;
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cond_first_r  <= LISF_STATUS_RESET;
         cond_second_r <= LISF_STATUS_RESET;
      end else begin
         cond_first_r  <= cond_first_nxt;
         cond_second_r <= cond_second_nxt;
      end
   end

   // ----------------------------------------
   // status registers
   // ----------------------------------------
   logic [7:0] flags_first;
   logic [7:0] flags_second;
   logic       rd_first;
   logic       rd_second;

   always_comb begin
      rd_first  = rd_en_in & (rd_addr_in == LISF_ADDR_STATUS_FIRST);
      rd_second = rd_en_in & (rd_addr_in == LISF_ADDR_STATUS_SECOND);
   end

   lisf_status_reg u_stat_first (
      .mclk_in     (mclk_in),
      .rstn_in     (rstn_in),
      .set_in      (set_first),
      .live_in     (cond_first_nxt),
      .impl_in     (8'hFF),
      .rd_clr_in   (rd_first),
      .soft_rst_in (soft_rst_in),
      .flags_out   (flags_first)
   );

   lisf_status_reg u_stat_second (
      .mclk_in     (mclk_in),
      .rstn_in     (rstn_in),
      .set_in      (set_second),
      .live_in     (cond_second_nxt),
      .impl_in     (LISF_SECOND_IMPL_MASK),
      .rd_clr_in   (rd_second),
      .soft_rst_in (soft_rst_in),
      .flags_out   (flags_second)
   );

   // ----------------------------------------
   // read data and interrupt pin
   // ----------------------------------------
   logic [7:0] rd_data_r;
   logic [7:0] rd_data_nxt;
   logic       int_r;
   logic       int_nxt;
   logic       any_flag;

   always_comb begin
      rd_data_nxt = rd_data_r;
      if (rd_first) begin
         rd_data_nxt = flags_first;
      end else if (rd_second) begin
         rd_data_nxt = flags_second & LISF_SECOND_IMPL_MASK;
      end else if (rd_en_in) begin
         rd_data_nxt = 8'h00;
      end
      any_flag = (|flags_first) | (|flags_second);
      int_nxt  = int_active_high_in ? any_flag : ~any_flag;
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rd_data_r <= LISF_STATUS_RESET;
         int_r     <= 1'b0;
      end else begin
         rd_data_r <= rd_data_nxt;
         int_r     <= int_nxt;
      end
   end

   assign rd_data_out = rd_data_r;
   assign int_out     = int_r;
endmodule

// file: rtl/lisf_pkg.sv
// package: register offsets, bit positions, reset values and sizes for the limit status flags
package lisf_pkg;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] LISF_ADDR_STATUS_FIRST  = 8'h00;
   localparam logic [7:0] LISF_ADDR_STATUS_SECOND = 8'h01;
   localparam logic [7:0] LISF_STATUS_RESET       = 8'h00;
   localparam logic [7:0] LISF_SECOND_IMPL_MASK   = 8'h1F;

   // ----------------------------------------
   // sizes
   // ----------------------------------------
   localparam int LISF_RES_W   = 10;
   localparam int LISF_LIM_W   = 8;
   localparam int LISF_NCHAN   = 10;

   // ----------------------------------------
   // channel indices
   // ----------------------------------------
   localparam int LISF_CH_INT  = 0;
   localparam int LISF_CH_EXT  = 1;
   localparam int LISF_CH_ANALOG_INPUT_2 = 2;
   localparam int LISF_CH_ANALOG_INPUT_5 = 5;
   localparam int LISF_CH_SUP  = 9;

   // ----------------------------------------
   // status-one and status-two bit positions
   // ----------------------------------------
   localparam int LISF_S1_INT_HIGH = 0;
   localparam int LISF_S1_INT_LOW  = 1;
   localparam int LISF_S1_EXT_HIGH = 2;
   localparam int LISF_S1_EXT_LOW  = 3;
   localparam int LISF_S1_FAULT    = 4;
   localparam int LISF_S1_ANALOG_INPUT_2     = 5;
   localparam int LISF_S2_ANALOG_INPUT_5     = 0;
   localparam int LISF_S2_SUPPLY   = 4;

   typedef enum logic {LISF_PINS_DIODE, LISF_PINS_ANALOG} lisf_pins_t;

endpackage

// file: rtl/lisf_limit_cmp.sv
// module: compares one 10-bit result with an 8-bit high and low limit
`timescale 1ns/10ps
module lisf_limit_cmp
   import lisf_pkg::*;
(
   // result and limits
   input  wire logic [LISF_RES_W-1:0] result_in,
   input  wire logic [LISF_LIM_W-1:0] high_lim_in,
   input  wire logic [LISF_LIM_W-1:0] low_lim_in,
   input  wire logic                  signed_in,
   // comparison outcome
   output logic                       above_out,
   output logic                       at_or_below_out
);
   logic [LISF_LIM_W-1:0] top_bits;

   // limits line up with the eight upper result bits; temperatures are twos complement
   always_comb begin
      top_bits = result_in[LISF_RES_W-1 -: LISF_LIM_W];
      if (signed_in) begin
         above_out       = $signed(top_bits) > $signed(high_lim_in);
         at_or_below_out = $signed(top_bits) <= $signed(low_lim_in);
      end else begin
         above_out       = top_bits > high_lim_in;
         at_or_below_out = top_bits <= low_lim_in;
      end
   end
endmodule

// file: rtl/lisf_status_reg.sv
// module: one 8-bit sticky status register with read-clear gated by live condition
`timescale 1ns/10ps
module lisf_status_reg
   import lisf_pkg::*;
(
   // clock and reset
   input  wire logic       mclk_in,
   input  wire logic       rstn_in,
   // events and clears
   input  wire logic [7:0] set_in,
   input  wire logic [7:0] live_in,
   input  wire logic [7:0] impl_in,
   input  wire logic       rd_clr_in,
   input  wire logic       soft_rst_in,
   // state
   output logic [7:0]      flags_out
);
   logic [7:0] flags_r;
   logic [7:0] flags_nxt;

   always_comb begin
      flags_nxt = flags_r;
      if (soft_rst_in) begin
         flags_nxt = LISF_STATUS_RESET;
      end else if (rd_clr_in) begin
         flags_nxt = flags_r & live_in;
      end
      flags_nxt = (flags_nxt | set_in) & impl_in;
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         flags_r <= LISF_STATUS_RESET;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   assign flags_out = flags_r;
endmodule

// file: bench/lisf_host_model.sv
// host model: issues single-byte status reads
`timescale 1ns/10ps
module lisf_host_model (
   // clock
   input  wire logic       mclk_in,
   // read strobe and address
   output logic            rd_en_out,
   output logic [7:0]      rd_addr_out
);
   initial begin
      rd_en_out = 1'b0;
      rd_addr_out = 8'h00;
   end
   // strobe for one cycle, then scramble the idle address
   task automatic rd(input logic [7:0] a);
      @(posedge mclk_in);
      #1 rd_en_out = 1'b1;
      rd_addr_out = a;
      @(posedge mclk_in);
      #1 rd_en_out = 1'b0;
      rd_addr_out = ~a;
   endtask
endmodule

// file: bench/lisf_top_props.sv
// checker: flag setting, read data and interrupt pin relations
`timescale 1ns/10ps
module lisf_top_props
   import lisf_pkg::*;
(
   // clock, reset and channel inputs
   input wire logic                                  mclk_in,
   input wire logic                                  rstn_in,
   input wire logic [LISF_NCHAN-1:0][LISF_RES_W-1:0] result_in,
   input wire logic [LISF_NCHAN-1:0]                 result_valid_in,
   input wire logic [LISF_NCHAN-1:0][LISF_LIM_W-1:0] high_lim_in,
   input wire logic [LISF_NCHAN-1:0][LISF_LIM_W-1:0] low_lim_in,
   // configuration, read port and pin
   input wire lisf_pins_t                            pin_mode_in,
   input wire logic [7:0]                            mask_first_in,
   input wire logic [7:0]                            mask_second_in,
   input wire logic                                  int_active_high_in,
   input wire logic                                  diode_fault_in,
   input wire logic                                  soft_rst_in,
   input wire logic                                  rd_en_in,
   input wire logic [7:0]                            rd_addr_in,
   input wire logic [7:0]                            rd_data_out,
   input wire logic                                  int_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   function automatic logic oow(input int c);
      return result_in[c][9:2] > high_lim_in[c] || result_in[c][9:2] <= low_lim_in[c];
   endfunction
   // a conversion out of limits shows in the read two cycles later
   property set_seen(cond, logic [7:0] a, int b);
      cond ##1 !soft_rst_in ##1 rd_en_in && rd_addr_in == a |=> rd_data_out[b];
   endproperty
   int_high_a: assert property (set_seen(result_valid_in[0] && !mask_first_in[0] &&
      $signed(result_in[0][9:2]) > $signed(high_lim_in[0]), 8'h00, 0)) else $error("no high flag");
   int_low_a: assert property (set_seen(result_valid_in[0] && !mask_first_in[1] &&
      $signed(result_in[0][9:2]) <= $signed(low_lim_in[0]), 8'h00, 1)) else $error("no low flag");
   analog_input_2_flag_a: assert property (set_seen(result_valid_in[2] && !mask_first_in[5]
      && oow(2), 8'h00, 5)) else $error("no input 2 flag");
   analog_input_5_flag_a: assert property (set_seen(result_valid_in[5] && !mask_second_in[0]
      && oow(5), 8'h01, 0)) else $error("no input 5 flag");
   supply_flag_a: assert property (set_seen(result_valid_in[9] && !mask_second_in[4]
      && oow(9), 8'h01, 4)) else $error("no supply flag");
   soft_clear_a: assert property (soft_rst_in && !(|result_valid_in) ##1 !(|result_valid_in)
      ##1 rd_en_in && rd_addr_in == 8'h01 |=> rd_data_out == 8'h00) else $error("soft clear");
   second_upper_a: assert property (rd_en_in && rd_addr_in == 8'h01
      |=> rd_data_out[7:5] == 3'h0) else $error("status two upper bits set");
   int_level_a: assert property ($past(rd_en_in) && rd_data_out != 8'h00
      && $stable(int_active_high_in) |-> int_out == int_active_high_in) else $error("pin idle");
   cover property (rd_en_in && rd_addr_in == 8'h01 ##1 rd_data_out != 8'h00);
   cover property (soft_rst_in);
   cover property ($rose(int_out));
endmodule
bind lisf_top lisf_top_props chk (.mclk_in, .rstn_in, .result_in, .result_valid_in,
   .high_lim_in, .low_lim_in, .pin_mode_in, .mask_first_in, .mask_second_in,
   .int_active_high_in, .diode_fault_in, .soft_rst_in, .rd_en_in, .rd_addr_in,
   .rd_data_out, .int_out);

// file: bench/tb_limit_interrupt_status_flags.sv
// testbench: drives conversions and reads, checks status bytes and interrupt pin
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_limit_interrupt_status_flags;
   import lisf_pkg::*;
   logic                                  mclk_in = 1'b0;
   logic                                  rstn_in = 1'b0;
   logic [LISF_NCHAN-1:0][LISF_RES_W-1:0] res = '0;
   logic [LISF_NCHAN-1:0]                 vld = '0;
   lisf_pins_t                            mode = LISF_PINS_DIODE;
   logic [7:0]                            mask1 = 8'h00;
   logic [7:0]                            mask2 = 8'h00;
   logic [7:0]                            lfsr = 8'h41;
   logic [7:0]                            rd_addr, rd_data, want;
   logic                                  pol = 1'b1, fault = 1'b0, srst = 1'b0, rd_en, irq;
   logic [7:0]                            expq[$];
   int                                    err_total = 0, num_checks = 0;
   always #2 mclk_in = ~mclk_in;
   lisf_host_model host (.mclk_in, .rd_en_out(rd_en), .rd_addr_out(rd_addr));
   lisf_top dut (.mclk_in, .rstn_in, .result_in(res), .result_valid_in(vld),
      .high_lim_in({LISF_NCHAN{8'h60}}), .low_lim_in({LISF_NCHAN{8'h10}}), .pin_mode_in(mode),
      .mask_first_in(mask1), .mask_second_in(mask2), .int_active_high_in(pol),
      .diode_fault_in(fault), .soft_rst_in(srst), .rd_en_in(rd_en), .rd_addr_in(rd_addr),
      .rd_data_out(rd_data), .int_out(irq));
   always @(posedge mclk_in) begin
      if (rd_en === 1'b1) begin
         #2 want = expq.pop_front();
         `CHK("rd_data_out", want, rd_data)
      end
   end
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic test_done();
      if (err_total == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic conv(input int ch, input logic [7:0] v);
      @(posedge mclk_in);
      #1 lfsr = lfsr_next(lfsr);
      res[ch] = {v, lfsr[1:0]};
      vld[ch] = 1'b1;
      @(posedge mclk_in);
      #1 vld[ch] = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      expq.push_back(e);
      host.rd(a);
   endtask
   task automatic int_chk(input logic act);
      repeat (2) @(posedge mclk_in);
      #1 `CHK("int_out", act ~^ pol, irq)
   endtask
   // set, persist, stay after recovery, then clear on read
   task automatic hit(input int ch, input lisf_pins_t m, input logic [7:0] v, a, e);
      mode = m;
      conv(ch, v);
      rd(a, e);
      rd(a, e);
      int_chk(e != 8'h00);
      conv(ch, 8'h20 + {2'b00, lfsr[5:0]});
      rd(a, e);
      rd(a, 8'h00);
      int_chk(1'b0);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge mclk_in);
      #1 rstn_in = 1'b1;
      rd(8'h00, 8'h00);
      rd(8'h01, 8'h00);
      int_chk(1'b0);
      hit(0, LISF_PINS_DIODE, 8'h61, 8'h00, 8'h01);
      hit(0, LISF_PINS_DIODE, 8'h60, 8'h00, 8'h00);
      hit(0, LISF_PINS_DIODE, 8'hF0, 8'h00, 8'h02);
      hit(1, LISF_PINS_DIODE, 8'h61, 8'h00, 8'h04);
      hit(1, LISF_PINS_DIODE, 8'h10, 8'h00, 8'h08);
      hit(1, LISF_PINS_ANALOG, 8'hF0, 8'h00, 8'h04);
      for (int c = 2; c < 5; c++) hit(c, LISF_PINS_ANALOG, 8'h10, 8'h00, 8'h01 << (c + 3));
      for (int c = 5; c < 9; c++) hit(c, LISF_PINS_ANALOG, 8'h61, 8'h01, 8'h01 << (c - 5));
      hit(9, LISF_PINS_ANALOG, 8'h10, 8'h01, 8'h10);
      mask1 = 8'h01;
      mask2 = 8'h10;
      conv(0, 8'h61);
      conv(9, 8'h61);
      rd(8'h00, 8'h00);
      rd(8'h01, 8'h00);
      mask1 = 8'h00;
      mask2 = 8'h00;
      conv(9, 8'h61);
      int_chk(1'b1);
      srst = 1'b1;
      @(posedge mclk_in);
      #1 srst = 1'b0;
      rd(8'h01, 8'h00);
      conv(9, 8'h30);
      mode = LISF_PINS_DIODE;
      fault = 1'b1;
      rd(8'h00, 8'h10);
      pol = 1'b0;
      int_chk(1'b1);
      fault = 1'b0;
      rd(8'h00, 8'h10);
      rd(8'h00, 8'h00);
      int_chk(1'b0);
      rd(8'h02, 8'h00);
      rd(8'hFF, 8'h00);
      repeat (2) @(posedge mclk_in);
      test_done();
   end
endmodule
